/* hw/nvmew_pkg.sv */
// Constants and types for the nvm word-write / row-erase sequencer.
// Assumes a 40 MHz system clock and a 32-bit Avalon-MM register bus.
`default_nettype none
package nvmew_pkg;
  // Register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_ADDR = 5'h04;
  localparam logic [4:0] OFF_DATA = 5'h08;
  localparam logic [4:0] OFF_KEY = 5'h0C;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  localparam logic [4:0] OFF_MASK = 5'h14;
  // Control register field positions
  localparam int CTRL_REGION = 0;
  localparam int CTRL_ERASE = 1;
  localparam int CTRL_WRITE_ENABLE_BIT = 2;
  localparam int CTRL_WSTART = 3;
  // Status and mask field positions
  localparam int STAT_DONE = 0;
  localparam int STAT_REFUSED = 1;
  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [14:0] ADDR_RST = 15'h0000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] STAT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  // Unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // Address map
  localparam logic [14:0] PFM_LAST = 15'h07FF;
  localparam logic [14:0] UID_LAST = 15'h0003;
  localparam logic [14:0] EE_BASE = 15'h7000;
  localparam logic [14:0] EE_LAST = 15'h70FF;
  localparam int ROW_LSB = 5;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int EE_PHASE_TIME_NS = 2000;
  localparam int ROW_ERASE_TIME_NS = 4000;
  localparam int EE_PHASE_CYC = (EE_PHASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_ERASE_CYC = (ROW_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EE_ERASE = 2'b01,
    ST_EE_WRITE = 2'b11,
    ST_ROW_ERASE = 2'b10
  } nvmew_state_t;
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_ARMED = 2'b11
  } nvmew_key_t;
endpackage : nvmew_pkg
`default_nettype wire

/* hw/nvmew_mem_if.sv */
// Port bundle between the sequencer and its EEPROM word array.
// Assumes one clock shared by both ends.
`default_nettype none
interface nvmew_mem_if;
  logic erase;
  logic write;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output erase, output write, output waddr, output wdata,
    output raddr, input rdata);
  modport mem (input erase, input write, input waddr, input wdata,
    input raddr, output rdata);
endinterface : nvmew_mem_if
`default_nettype wire

/* hw/nvmew_mem.sv */
// EEPROM word array: erase sets a word blank, write stores a word.
// Assumes erase and write never come in the same cycle.
`default_nettype none
module nvmew_mem (
  // Clock
  input wire logic i_clk_sys,
  // Sequencer side
  nvmew_mem_if.mem m
);
  logic [7:0] arr [256];

  always_ff @(posedge i_clk_sys)
  begin
    if (m.erase)
    begin
      arr[m.waddr] <= 8'hFF;
    end
    else if (m.write)
    begin
      arr[m.waddr] <= m.wdata;
    end
    m.rdata <= arr[m.raddr];
  end
endmodule : nvmew_mem
`default_nettype wire

/* hw/nvmew_top.sv */
// Nvm sequencer: EEPROM word write with implicit erase, flash row erase.
// Assumes a CPU master on Avalon-MM and an external flash erase engine.
//
// Contract
// - One EEPROM word per operation, erased automatically first.
// - CPU runs on during EEPROM write; completion clears write-start, sets done flag.
// - Done flag together with its enable raises the interrupt.
// - Clearing write-start during an EEPROM write is ignored.
// - No automatic program flash erase on a program flash write.
// - Program flash erases one whole row per operation.
// - Protected row: write-start cleared, no erase.
// - Row erase stalls the CPU, then sets done flag and maybe interrupts.
// - Erase leaves write latches alone; write-enable never changed by hardware.
// - Region-select and address decode into flash, user ID, config, EEPROM; code has no config decode and refuses that space.
// - Start needs 55h, AAh to key register, then write-start, uninterrupted.
// - Code protection refuses every operation.
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`default_nettype none
module nvmew_top
  import nvmew_pkg::*;
#(
  parameter int EE_PHASE_CYCLES = EE_PHASE_CYC,
  parameter int ROW_ERASE_CYCLES = ROW_ERASE_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Protection
  input wire logic i_code_protect,
  input wire logic [14:0] i_wp_limit,
  // Program flash erase engine
  output logic o_pfm_erase,
  output logic o_pfm_uid_space,
  output logic [9:0] o_pfm_row,
  output logic o_cpu_stall,
  // EEPROM read-back
  input wire logic [7:0] i_ee_raddr,
  output logic [7:0] o_ee_rdata,
  // Interrupt
  output logic o_irq
);
  if (EE_PHASE_CYCLES < 8 || EE_PHASE_CYCLES >= 2 ** CNT_W ||
      ROW_ERASE_CYCLES < 8 || ROW_ERASE_CYCLES >= 2 ** CNT_W)
  begin : g_bad_cycles
    $error("nvmew_top: cycle counts out of range");
  end

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction : be_merge
  nvmew_state_t state;
  nvmew_state_t next_state;
  nvmew_key_t key_st;
  nvmew_key_t next_key;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic region;
  logic erase_sel;
  logic write_enable_bit;
  logic wstart;
  logic [14:0] addr;
  logic [7:0] data;
  logic [1:0] status;
  logic [1:0] mask;
  logic [7:0] ee_waddr;
  logic [7:0] ee_wdata;
  logic rd_pend;
  nvmew_mem_if mif ();
  nvmew_mem u_mem (
    .i_clk_sys(i_clk_sys),
    .m(mif.mem)
  );
  // Bus decode
  wire [4:0] adr = {i_avs_address[4:2], 2'b00};
  wire wr_ctrl = i_avs_write && adr == OFF_CTRL;
  wire wr_addr = i_avs_write && adr == OFF_ADDR;
  wire wr_data = i_avs_write && adr == OFF_DATA;
  wire wr_key = i_avs_write && adr == OFF_KEY && i_avs_byteenable[0];
  wire wr_stat = i_avs_write && adr == OFF_STATUS;
  wire wr_mask = i_avs_write && adr == OFF_MASK;
  wire [31:0] ctrl_cur = {28'h0000000, wstart, write_enable_bit, erase_sel, region};
  wire [31:0] ctrl_wd = be_merge(ctrl_cur, i_avs_writedata, i_avs_byteenable);
  wire [31:0] addr_wd = be_merge({17'h00000, addr}, i_avs_writedata, i_avs_byteenable);
  wire [31:0] data_wd = be_merge({24'h000000, data}, i_avs_writedata, i_avs_byteenable);
  wire [31:0] mask_wd = be_merge({30'h00000000, mask}, i_avs_writedata, i_avs_byteenable);
  wire [31:0] stat_w1c = be_merge(32'h00000000, i_avs_writedata, i_avs_byteenable);
  wire [31:0] rd_mux =
    (adr == OFF_CTRL) ? ctrl_cur :
    (adr == OFF_ADDR) ? {17'h00000, addr} :
    (adr == OFF_DATA) ? {24'h000000, data} :
    (adr == OFF_STATUS) ? {30'h00000000, status} :
    (adr == OFF_MASK) ? {30'h00000000, mask} :
    32'h00000000;

  // Operation decode
  wire idle = state == ST_IDLE;
  wire start_req = wr_ctrl && ctrl_wd[CTRL_WSTART] && idle;
  wire key_ok = key_st == KEY_ARMED;
  wire go = start_req && key_ok && ctrl_wd[CTRL_WRITE_ENABLE_BIT] && !i_code_protect;
  wire in_ee = ctrl_wd[CTRL_REGION] && addr >= EE_BASE && addr <= EE_LAST;
  wire in_uid = ctrl_wd[CTRL_REGION] && addr <= UID_LAST;
  wire in_pfm = !ctrl_wd[CTRL_REGION] && addr <= PFM_LAST;
  wire prot = in_pfm && addr < i_wp_limit;
  wire do_ee = go && in_ee;
  wire do_erase = go && !in_ee && ctrl_wd[CTRL_ERASE] && (in_uid || (in_pfm && !prot));
  wire refuse = start_req && key_ok && ctrl_wd[CTRL_WRITE_ENABLE_BIT] && !do_ee && !do_erase;
  wire phase_end = cnt == '0;
  wire done_evt = (state == ST_EE_WRITE || state == ST_ROW_ERASE) && phase_end;
  wire [1:0] events = {refuse, done_evt};

  // Sequencer
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ST_IDLE:
      begin
        if (do_ee)
        begin
          next_state = ST_EE_ERASE;
          next_cnt = CNT_W'(EE_PHASE_CYCLES - 1);
        end
        else if (do_erase)
        begin
          next_state = ST_ROW_ERASE;
          next_cnt = CNT_W'(ROW_ERASE_CYCLES - 1);
        end
      end
      ST_EE_ERASE:
      begin
        if (phase_end)
        begin
          next_state = ST_EE_WRITE;
          next_cnt = CNT_W'(EE_PHASE_CYCLES - 1);
        end
        else
        begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_EE_WRITE, ST_ROW_ERASE:
      begin
        if (phase_end)
        begin
          next_state = ST_IDLE;
        end
        else
        begin
          next_cnt = cnt - 1'b1;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end
  // Unlock key tracker: any other write breaks the sequence
  wire key_step1 = wr_key && i_avs_writedata[7:0] == KEY_FIRST;
  wire key_step2 = wr_key && i_avs_writedata[7:0] == KEY_SECOND && key_st == KEY_HALF;
  assign next_key = !i_avs_write ? key_st : key_step1 ? KEY_HALF :
    key_step2 ? KEY_ARMED : KEY_IDLE;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state <= ST_IDLE;
      key_st <= KEY_IDLE;
      cnt <= '0;
    end
    else
    begin
      state <= next_state;
      key_st <= next_key;
      cnt <= next_cnt;
    end
  end
  // Control register; hardware never touches write-enable
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      {write_enable_bit, erase_sel, region} <= CTRL_RST[2:0];
    else if (wr_ctrl)
      {write_enable_bit, erase_sel, region} <= ctrl_wd[2:0];
  end
  // Write-start: set only by a good start, cleared only on completion
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      wstart <= CTRL_RST[CTRL_WSTART];
    else if (do_ee || do_erase)
      wstart <= 1'b1;
    else if (done_evt)
      wstart <= 1'b0;
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      addr <= ADDR_RST;
      data <= DATA_RST;
      mask <= MASK_RST;
      status <= STAT_RST;
    end
    else
    begin
      addr <= wr_addr ? addr_wd[14:0] : addr;
      data <= wr_data ? data_wd[7:0] : data;
      mask <= wr_mask ? mask_wd[1:0] : mask;
      status <= (status & ~(wr_stat ? stat_w1c[1:0] : 2'h0)) | events;
    end
  end

  // Operation latches
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ee_waddr <= 8'h00;
      ee_wdata <= 8'h00;
      o_pfm_row <= 10'h000;
      o_pfm_uid_space <= 1'b0;
      o_pfm_erase <= 1'b0;
    end
    else
    begin
      if (do_ee)
      begin
        ee_waddr <= addr[7:0];
        ee_wdata <= data;
      end
      if (do_erase)
      begin
        o_pfm_row <= addr[14:ROW_LSB];
        o_pfm_uid_space <= ctrl_wd[CTRL_REGION];
      end
      o_pfm_erase <= do_erase;
    end
  end

  // Bus read path: one wait state per read
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rd_pend <= 1'b0;
      o_avs_readdata <= 32'h00000000;
    end
    else
    begin
      rd_pend <= i_avs_read && !rd_pend;
      if (i_avs_read && !rd_pend)
        o_avs_readdata <= rd_mux;
    end
  end

  assign o_avs_waitrequest = i_avs_read && !rd_pend;
  assign o_cpu_stall = state == ST_ROW_ERASE;
  assign o_irq = |(status & mask);
  assign o_ee_rdata = mif.rdata;
  assign mif.erase = state == ST_EE_ERASE && phase_end;
  assign mif.write = state == ST_EE_WRITE && phase_end;
  assign mif.waddr = ee_waddr;
  assign mif.wdata = ee_wdata;
  assign mif.raddr = i_ee_raddr;

  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  start_key_a: assert property ((idle ##1 !idle) |-> $past(key_st) == KEY_ARMED)
    else $error("operation started without unlock");
  no_write_enable_bit_a: assert property ((start_req && !ctrl_wd[CTRL_WRITE_ENABLE_BIT]) |=> idle && !wstart)
    else $error("start accepted with write-enable clear");
  code_prot_a: assert property ((start_req && i_code_protect) |=> idle && !wstart)
    else $error("operation started under code protection");
  ee_erase_first_a: assert property ($rose(state == ST_EE_WRITE) |-> $past(mif.erase))
    else $error("EEPROM write without prior erase");
  ee_done_a: assert property ((state == ST_EE_WRITE && phase_end) |=>
      idle && !wstart && status[STAT_DONE])
    else $error("EEPROM completion not flagged");
  wr_hold_a: assert property ((state == ST_EE_ERASE || state == ST_EE_WRITE) |-> wstart)
    else $error("write-start dropped during EEPROM write");
  irq_rise_a: assert property (($rose(status[STAT_DONE]) && mask[STAT_DONE]) |-> o_irq)
    else $error("done interrupt missing");
  stall_end_a: assert property ($fell(o_cpu_stall) |-> status[STAT_DONE] && !wstart)
    else $error("row erase end not flagged");
  row_stall_a: assert property ((idle && do_erase) |=> o_cpu_stall[*8])
    else $error("CPU not stalled during row erase");
  wp_block_a: assert property ((start_req && key_ok && prot && ctrl_wd[CTRL_ERASE] &&
      ctrl_wd[CTRL_WRITE_ENABLE_BIT]) |=> !wstart && !o_pfm_erase && status[STAT_REFUSED])
    else $error("protected row erased");
  one_row_a: assert property (o_pfm_erase |=> !o_pfm_erase ##1 o_cpu_stall)
    else $error("erase pulse longer than one row");
  no_auto_a: assert property (o_pfm_erase |-> $past(ctrl_wd[CTRL_ERASE]))
    else $error("erase without erase-select");
  write_enable_bit_keep_a: assert property ((!idle && !wr_ctrl) |=> $stable(write_enable_bit))
    else $error("write-enable changed by hardware");
  ee_range_a: assert property ($rose(state == ST_EE_ERASE) |-> $past(in_ee))
    else $error("EEPROM write outside EEPROM range");

  ee_write_c: cover property (state == ST_EE_WRITE && phase_end);
  row_erase_c: cover property ($fell(o_cpu_stall));
  refused_c: cover property (refuse);
  key_break_c: cover property (key_st == KEY_HALF ##1 key_st == KEY_IDLE);
endmodule : nvmew_top
`default_nettype wire

/* tb/nvmew_top_test.sv */
// Self-checking bench for the nvm word-write / row-erase sequencer.
// Assumes the sequencer top and package from hw/, phase counts shortened to 8.
`default_nettype none
module nvmew_top_test;
  import nvmew_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PH = 8;
  logic clk, rstn, rd, wr, cp, waitreq, irq, erase_go, uid_o, stall;
  logic [4:0] adr;
  logic [31:0] wdat, rdata;
  logic [14:0] wp;
  logic [9:0] row_o, row_seen;
  logic [7:0] ee_a, ee_d;
  int err_total, total_checks, pulses, stall_cyc;
  logic uid_seen;

  nvmew_top #(.EE_PHASE_CYCLES(PH), .ROW_ERASE_CYCLES(PH)) dut (
    .i_clk_sys(clk), .i_resetn(rstn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_code_protect(cp),
    .i_wp_limit(wp), .o_pfm_erase(erase_go), .o_pfm_uid_space(uid_o),
    .o_pfm_row(row_o), .o_cpu_stall(stall), .i_ee_raddr(ee_a),
    .o_ee_rdata(ee_d), .o_irq(irq));

  // Erase requests and stall length seen at the ports
  always @(posedge clk)
  begin
    if (erase_go === 1'b1)
    begin
      pulses <= pulses + 1;
      row_seen <= row_o;
      uid_seen <= uid_o;
    end
    if (stall === 1'b1)
      stall_cyc <= stall_cyc + 1;
  end

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : check

  // One bus transfer; held until waitrequest is low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] q);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (waitreq !== 1'b0)
      @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr32(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr32

  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask : rd_chk

  task automatic start(input logic [3:0] c, input logic [14:0] a);
    wr32(OFF_CTRL, {28'h0, c});
    wr32(OFF_ADDR, {17'h0, a});
    wr32(OFF_KEY, 32'h55);
    wr32(OFF_KEY, 32'hAA);
    wr32(OFF_CTRL, {28'h0, c | 4'h8});
  endtask : start

  task automatic wait_idle();
    logic [31:0] q;
    int n;
    q = 32'h8;
    for (n = 0; n < 100 && q[CTRL_WSTART] !== 1'b0; n++)
      bus(1'b0, OFF_CTRL, 32'h0, q);
    check("busy", {31'h0, q[CTRL_WSTART]}, 32'h0);
  endtask : wait_idle

  task automatic t_reset();
    for (int o = 0; o < 7; o++)
      rd_chk("reset reg", 5'(o * 4), 32'h0);
    check("irq idle", {31'h0, irq}, 32'h0);
  endtask : t_reset

  task automatic t_eeprom();
    int s0;
    s0 = stall_cyc;
    wr32(OFF_DATA, 32'hA5);
    start(4'h5, 15'h7005);
    rd_chk("ee started", OFF_CTRL, 32'hD);
    wr32(OFF_CTRL, 32'h5);
    rd_chk("clear ignored", OFF_CTRL, 32'hD);
    wait_idle();
    check("ee no stall", stall_cyc, s0);
    rd_chk("ee ctrl", OFF_CTRL, 32'h5);
    rd_chk("ee done", OFF_STATUS, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr32(OFF_MASK, 32'h1);
    check("irq on", {31'h0, irq}, 32'h1);
    wr32(OFF_STATUS, 32'h1);
    check("irq off", {31'h0, irq}, 32'h0);
    ee_a <= 8'h05;
    repeat (2) @(posedge clk);
    check("ee word", {24'h0, ee_d}, 32'hA5);
  endtask : t_eeprom

  task automatic t_row(input logic [3:0] c, input logic [14:0] a);
    int p0, s0;
    p0 = pulses;
    s0 = stall_cyc;
    start(c, a);
    wait_idle();
    check("one pulse", pulses, p0 + 1);
    check("row", {22'h0, row_seen}, {22'h0, a[14:5]});
    check("uid space", {31'h0, uid_seen}, {31'h0, c[CTRL_REGION]});
    check("stall len", stall_cyc, s0 + PH);
    rd_chk("row ctrl", OFF_CTRL, {28'h0, c});
    rd_chk("row done", OFF_STATUS, 32'h1);
    check("row irq", {31'h0, irq}, 32'h1);
    wr32(OFF_STATUS, 32'h1);
  endtask : t_row

  // Start attempt that must not run; expected status given
  task automatic t_deny(input logic [3:0] c, input logic [14:0] a, input logic p,
    input logic [31:0] st);
    int p0;
    p0 = pulses;
    cp <= p;
    start(c, a);
    rd_chk("denied ctrl", OFF_CTRL, {28'h0, c});
    rd_chk("denied status", OFF_STATUS, st);
    check("no erase", pulses, p0);
    cp <= 1'b0;
    wr32(OFF_STATUS, 32'h3);
  endtask : t_deny

  task automatic t_broken_key();
    wr32(OFF_CTRL, 32'h5);
    wr32(OFF_KEY, 32'h55);
    wr32(OFF_DATA, 32'h11);
    wr32(OFF_KEY, 32'hAA);
    wr32(OFF_CTRL, 32'hD);
    rd_chk("key broken", OFF_CTRL, 32'h5);
    rd_chk("key status", OFF_STATUS, 32'h0);
  endtask : t_broken_key

  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  initial
  begin
    {rstn, rd, wr, cp, adr, wdat, ee_a} = '0;
    {err_total, total_checks, pulses, stall_cyc} = '0;
    wp = 15'h0020;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_eeprom();
    t_row(4'h6, 15'h0040);
    t_row(4'h7, 15'h0002);
    t_deny(4'h5, 15'h7010, 1'b1, 32'h2);
    t_deny(4'h6, 15'h0010, 1'b0, 32'h2);
    t_deny(4'h4, 15'h0100, 1'b0, 32'h2);
    t_deny(4'h7, 15'h0007, 1'b0, 32'h2);
    t_deny(4'h5, 15'h7100, 1'b0, 32'h2);
    t_deny(4'h1, 15'h7010, 1'b0, 32'h0);
    t_broken_key();
    wrap_up();
  end
endmodule : nvmew_top_test
`default_nettype wire
